// >>> hw/nac_pkg.sv
// Package: constants and types of the nonvolatile access control block
package nac_pkg;
  // Clock and self-timed cycle lengths
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ERASE_TIME_NS = 2000;
  localparam int unsigned PROG_TIME_NS  = 2000;
  localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W     = 8;
  localparam logic [TMR_W-1:0] ERASE_LOAD = TMR_W'(ERASE_CYC - 1);
  localparam logic [TMR_W-1:0] PROG_LOAD  = TMR_W'(PROG_CYC - 1);
  // Widths and depth
  localparam int unsigned DW    = 8;
  localparam int unsigned AW    = 10;
  localparam int unsigned AH_W  = 2;
  localparam int unsigned DEPTH = 1024;
  localparam int unsigned TPU_W = 6;
  localparam int unsigned RA_W  = 4;
  // Register offsets
  localparam logic [RA_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [RA_W-1:0] OFF_UNLOCK = 4'h1;
  localparam logic [RA_W-1:0] OFF_DATA   = 4'h2;
  localparam logic [RA_W-1:0] OFF_ADL    = 4'h3;
  localparam logic [RA_W-1:0] OFF_ADH    = 4'h4;
  localparam logic [RA_W-1:0] OFF_TPL    = 4'h5;
  localparam logic [RA_W-1:0] OFF_TPH    = 4'h6;
  localparam logic [RA_W-1:0] OFF_TPU    = 4'h7;
  localparam logic [RA_W-1:0] OFF_TABLE_DATA_LATCH = 4'h8;
  localparam logic [RA_W-1:0] OFF_PERIPHERAL_FLAGS_TWO   = 4'h9;
  localparam logic [RA_W-1:0] OFF_PERIPHERAL_ENABLES_TWO   = 4'ha;
  localparam logic [RA_W-1:0] OFF_PERIPHERAL_PRIORITY_TWO   = 4'hb;
  localparam logic [RA_W-1:0] OFF_INTERRUPT_CONTROL = 4'hc;
  // Control register bit positions; B_DONE is the done bit of the peripheral flags register
  localparam int unsigned B_RD    = 0;
  localparam int unsigned B_WR    = 1;
  localparam int unsigned B_WRITE_ENABLE_BIT  = 2;
  localparam int unsigned B_WRITE_ERROR_FLAG = 3;
  localparam int unsigned B_FREE  = 4;
  localparam int unsigned B_UNIMP = 5;
  localparam int unsigned B_CONFIG_SPACE_SELECT  = 6;
  localparam int unsigned B_PGD   = 7;
  localparam int unsigned B_DONE  = 4;
  // Unlock values, erased byte, reset value
  localparam logic [DW-1:0] UNLOCK_1 = 8'h55;
  localparam logic [DW-1:0] UNLOCK_2 = 8'haa;
  localparam logic [DW-1:0] ERASED   = 8'hff;
  localparam logic [DW-1:0] REG_RST  = 8'h00;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT1, SEQ_ARMED} nac_seq_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_ERASE, ENG_PROG} nac_eng_t;
endpackage

// >>> hw/nac_arr_if.sv
// Interface between the control logic and the self-timed array engine
`timescale 1ns/1ps
`default_nettype none
interface nac_arr_if;
  logic                       start;
  logic                       use_array;
  logic                       do_erase;
  logic                       do_prog;
  logic                       abort;
  logic [nac_pkg::AW-1:0]     addr;
  logic [nac_pkg::DW-1:0]     wdata;
  logic [nac_pkg::DW-1:0]     rd_data;
  logic                       done;
  logic                       busy;
  modport ctl (output start, use_array, do_erase, do_prog, abort, addr, wdata,
               input rd_data, done, busy);
  modport eng (input start, use_array, do_erase, do_prog, abort, addr, wdata,
               output rd_data, done, busy);
endinterface
`default_nettype wire

// >>> hw/nac_engine.sv
// Self-timed erase and program engine with the data byte array
`timescale 1ns/1ps
`default_nettype none
module nac_engine (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  nac_arr_if.eng      arr
);
  logic [nac_pkg::DW-1:0]    mem [0:nac_pkg::DEPTH-1];
  nac_pkg::nac_eng_t         state_ff;
  logic [nac_pkg::TMR_W-1:0] tmr_ff;
  logic [nac_pkg::AW-1:0]    addr_ff;
  logic [nac_pkg::DW-1:0]    data_ff;
  logic                      arr_ff;
  logic                      prog_ff;
  logic                      done_ff;
  logic                      tmr_end;

  assign tmr_end = (tmr_ff == '0);

  // Phase sequencer timed by the internal counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= nac_pkg::ENG_IDLE;
      tmr_ff   <= '0;
      done_ff  <= 1'h0;
    end else if (ce) begin
      done_ff <= 1'h0;
      if (arr.abort) begin
        state_ff <= nac_pkg::ENG_IDLE;
      end else begin
        case (state_ff)
          nac_pkg::ENG_IDLE: begin
            if (arr.start && arr.do_erase) begin
              state_ff <= nac_pkg::ENG_ERASE;
              tmr_ff   <= nac_pkg::ERASE_LOAD;
            end else if (arr.start) begin
              state_ff <= nac_pkg::ENG_PROG;
              tmr_ff   <= nac_pkg::PROG_LOAD;
            end
          end
          nac_pkg::ENG_ERASE: begin
            if (!tmr_end) begin
              tmr_ff <= tmr_ff - 1'h1;
            end else if (prog_ff) begin
              state_ff <= nac_pkg::ENG_PROG;
              tmr_ff   <= nac_pkg::PROG_LOAD;
            end else begin
              state_ff <= nac_pkg::ENG_IDLE;
              done_ff  <= 1'h1;
            end
          end
          nac_pkg::ENG_PROG: begin
            if (!tmr_end) begin
              tmr_ff <= tmr_ff - 1'h1;
            end else begin
              state_ff <= nac_pkg::ENG_IDLE;
              done_ff  <= 1'h1;
            end
          end
          default: state_ff <= nac_pkg::ENG_IDLE;
        endcase
      end
    end
  end

  // Operation sampled at launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      data_ff <= '0;
      arr_ff  <= 1'h0;
      prog_ff <= 1'h0;
    end else if (ce && arr.start && state_ff == nac_pkg::ENG_IDLE) begin
      addr_ff <= arr.addr;
      data_ff <= arr.wdata;
      arr_ff  <= arr.use_array;
      prog_ff <= arr.do_prog;
    end
  end

  // Array update at the end of each phase
  always_ff @(posedge clk) begin
    if (ce && tmr_end && arr_ff && !arr.abort) begin
      if (state_ff == nac_pkg::ENG_ERASE) begin
        mem[addr_ff] <= nac_pkg::ERASED;
      end else if (state_ff == nac_pkg::ENG_PROG) begin
        mem[addr_ff] <= data_ff;
      end
    end
  end

  assign arr.rd_data = mem[arr.addr];
  assign arr.done    = done_ff;
  assign arr.busy    = (state_ff != nac_pkg::ENG_IDLE);

  property p_erase_first;
    @(posedge clk) disable iff (rst)
    ($rose(state_ff == nac_pkg::ENG_PROG) && arr_ff) |-> $past(state_ff == nac_pkg::ENG_ERASE);
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("program without erase");
endmodule
`default_nettype wire

// >>> hw/nac_top.sv
// Top of the nonvolatile access control block: registers, unlock and launch
`timescale 1ns/1ps
`default_nettype none
module nac_top (
  input  wire logic                            CORE_CLK,
  input  wire logic                            SYS_RST,
  input  wire logic                            CE,
  input  wire logic                            EXT_RESET_N,
  input  wire logic                            WDT_TIMEOUT,
  input  wire logic [nac_pkg::RA_W-1:0]        REG_ADDR,
  input  wire logic [nac_pkg::DW-1:0]          REG_WDATA,
  input  wire logic                            REG_WR,
  input  wire logic                            REG_RD,
  output wire logic [nac_pkg::DW-1:0]          REG_RDATA,
  output wire logic                            NVM_BUSY,
  output wire logic                            FLASH_ERASE_STB,
  output wire logic                            FLASH_WRITE_STB,
  output wire logic                            CFG_WRITE_STB,
  output wire logic [nac_pkg::TPU_W+15:0]      FLASH_ADDR,
  output wire logic [nac_pkg::DW-1:0]          FLASH_DATA
);
  // Control register bits
  logic                       pgd_ff;
  logic                       config_space_select_ff;
  logic                       free_ff;
  logic                       write_error_flag_ff;
  logic                       write_enable_bit_ff;
  logic                       wr_ff;
  logic                       rd_ff;
  logic                       free_op_ff;
  // Byte registers
  logic [nac_pkg::DW-1:0]     data_ff;
  logic [nac_pkg::DW-1:0]     adl_ff;
  logic [nac_pkg::AH_W-1:0]   adh_ff;
  logic [nac_pkg::TPU_W-1:0]  tpu_ff;
  logic [nac_pkg::DW-1:0]     tph_ff, tpl_ff, table_data_latch_ff;
  logic [nac_pkg::DW-1:0]     interrupt_control_ff, peripheral_flags_two_ff, peripheral_enables_two_ff, peripheral_priority_two_ff;
  logic [nac_pkg::DW-1:0]     rdata_ff, nxt_rdata, ctrl_rd;
  // Sequence, synchronisers, strobes, decode
  nac_pkg::nac_seq_t          seq_ff, nxt_seq;
  logic                       ext_meta_ff, ext_sync_ff, wdt_meta_ff, wdt_sync_ff;
  logic                       erase_stb_ff, write_stb_ff, cfg_stb_ff;
  logic                       soft_rst, ctrl_wr, take, wr_req, launch, improper;
  logic                       rd_req, tgt_data, tgt_erase;

  nac_arr_if arr ();

  // Register hit for a strobe at an offset
  function automatic logic hit(input logic stb, input logic [nac_pkg::RA_W-1:0] a,
                               input logic [nac_pkg::RA_W-1:0] off);
    return stb && (a == off);
  endfunction

  // Two-stage synchronisers for the reset request pins
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ext_meta_ff <= 1'h1;
      ext_sync_ff <= 1'h1;
      wdt_meta_ff <= 1'h0;
      wdt_sync_ff <= 1'h0;
    end else if (CE) begin
      ext_meta_ff <= EXT_RESET_N;
      ext_sync_ff <= ext_meta_ff;
      wdt_meta_ff <= WDT_TIMEOUT;
      wdt_sync_ff <= wdt_meta_ff;
    end
  end

  // Launch and read decode
  assign soft_rst  = !ext_sync_ff || wdt_sync_ff;
  assign ctrl_wr   = hit(REG_WR, REG_ADDR, nac_pkg::OFF_CTRL);
  assign take      = ctrl_wr && !wr_ff;
  assign wr_req    = take && REG_WDATA[nac_pkg::B_WR];
  assign launch    = wr_req && write_enable_bit_ff && (seq_ff == nac_pkg::SEQ_ARMED) && !soft_rst;
  assign improper  = wr_req && !launch;
  assign rd_req    = take && REG_WDATA[nac_pkg::B_RD] && !launch
                     && !REG_WDATA[nac_pkg::B_PGD] && !REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT];
  assign tgt_data  = !REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT] && !REG_WDATA[nac_pkg::B_PGD];
  assign tgt_erase = !REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT] && REG_WDATA[nac_pkg::B_PGD]
                     && REG_WDATA[nac_pkg::B_FREE];

  // Engine request
  assign arr.start     = launch;
  assign arr.use_array = tgt_data;
  assign arr.do_erase  = tgt_data || tgt_erase;
  assign arr.do_prog   = !tgt_erase;
  assign arr.abort     = soft_rst;
  assign arr.addr      = {adh_ff, adl_ff};
  assign arr.wdata     = data_ff;

  nac_engine u_engine (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .ce  (CE),
    .arr (arr)
  );

  // Write start, error flag and read start
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ff      <= 1'h0;
      write_error_flag_ff   <= 1'h0;
      rd_ff      <= 1'h0;
      free_op_ff <= 1'h0;
    end else if (CE) begin
      rd_ff <= rd_req && !soft_rst;
      if (soft_rst) begin
        wr_ff <= 1'h0;
      end else if (launch) begin
        wr_ff      <= 1'h1;
        write_error_flag_ff   <= 1'h1;
        free_op_ff <= tgt_erase;
      end else if (arr.done) begin
        wr_ff    <= 1'h0;
        write_error_flag_ff <= 1'h0;
      end else if (improper) begin
        write_error_flag_ff <= 1'h1;
      end else if (take) begin
        write_error_flag_ff <= REG_WDATA[nac_pkg::B_WRITE_ERROR_FLAG];
      end
    end
  end

  // Space selects, block erase and write enable
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pgd_ff  <= 1'h0;
      config_space_select_ff <= 1'h0;
      free_ff <= 1'h0;
      write_enable_bit_ff <= 1'h0;
    end else if (CE) begin
      if (soft_rst) begin
        // Space selects kept for tracing a failed write
        free_ff <= 1'h0;
        write_enable_bit_ff <= 1'h0;
      end else if (take) begin
        pgd_ff  <= REG_WDATA[nac_pkg::B_PGD];
        config_space_select_ff <= REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT];
        free_ff <= REG_WDATA[nac_pkg::B_FREE];
        write_enable_bit_ff <= REG_WDATA[nac_pkg::B_WRITE_ENABLE_BIT];
      end else if (arr.done && free_op_ff) begin
        free_ff <= 1'h0;
      end
    end
  end

  // Unlock sequence tracker
  always_comb begin
    nxt_seq = nac_pkg::SEQ_IDLE;
    if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_UNLOCK) && !wr_ff) begin
      if (REG_WDATA == nac_pkg::UNLOCK_1) begin
        nxt_seq = nac_pkg::SEQ_GOT1;
      end else if (seq_ff == nac_pkg::SEQ_GOT1 && REG_WDATA == nac_pkg::UNLOCK_2) begin
        nxt_seq = nac_pkg::SEQ_ARMED;
      end
    end else if (!REG_WR) begin
      nxt_seq = seq_ff;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      seq_ff <= nac_pkg::SEQ_IDLE;
    end else if (CE) begin
      seq_ff <= soft_rst ? nac_pkg::SEQ_IDLE : nxt_seq;
    end
  end

  // Data byte and address registers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      data_ff <= nac_pkg::REG_RST;
      adl_ff  <= nac_pkg::REG_RST;
      adh_ff  <= '0;
    end else if (CE) begin
      if (rd_req && !soft_rst) begin
        data_ff <= arr.rd_data;
      end else if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_DATA) && !wr_ff) begin
        data_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_ADL) && !wr_ff) begin
        adl_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_ADH) && !wr_ff) begin
        adh_ff <= REG_WDATA[nac_pkg::AH_W-1:0];
      end
    end
  end

  // Table pointer and table latch
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tpu_ff    <= '0;
      tph_ff    <= nac_pkg::REG_RST;
      tpl_ff    <= nac_pkg::REG_RST;
      table_data_latch_ff <= nac_pkg::REG_RST;
    end else if (CE) begin
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_TPU)) begin
        tpu_ff <= REG_WDATA[nac_pkg::TPU_W-1:0];
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_TPH)) begin
        tph_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_TPL)) begin
        tpl_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_TABLE_DATA_LATCH)) begin
        table_data_latch_ff <= REG_WDATA;
      end
    end
  end

  // Interrupt side registers; completion set beats a software clear
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      peripheral_flags_two_ff   <= nac_pkg::REG_RST;
      peripheral_enables_two_ff   <= nac_pkg::REG_RST;
      peripheral_priority_two_ff   <= nac_pkg::REG_RST;
      interrupt_control_ff <= nac_pkg::REG_RST;
    end else if (CE) begin
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_PERIPHERAL_FLAGS_TWO)) begin
        peripheral_flags_two_ff <= REG_WDATA;
      end
      if (arr.done && !soft_rst) begin
        peripheral_flags_two_ff[nac_pkg::B_DONE] <= 1'h1;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_PERIPHERAL_ENABLES_TWO)) begin
        peripheral_enables_two_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_PERIPHERAL_PRIORITY_TWO)) begin
        peripheral_priority_two_ff <= REG_WDATA;
      end
      if (hit(REG_WR, REG_ADDR, nac_pkg::OFF_INTERRUPT_CONTROL)) begin
        interrupt_control_ff <= REG_WDATA;
      end
    end
  end

  // One-cycle strobes to the flash and configuration arrays
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      erase_stb_ff <= 1'h0;
      write_stb_ff <= 1'h0;
      cfg_stb_ff   <= 1'h0;
    end else if (CE) begin
      erase_stb_ff <= launch && tgt_erase;
      write_stb_ff <= launch && !tgt_data && !tgt_erase
                      && !REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT];
      cfg_stb_ff   <= launch && REG_WDATA[nac_pkg::B_CONFIG_SPACE_SELECT];
    end
  end

  // Read multiplexer; unmapped offsets read zero
  assign ctrl_rd = {pgd_ff, config_space_select_ff, 1'h0, free_ff, write_error_flag_ff, write_enable_bit_ff, wr_ff, rd_ff};

  always_comb begin
    nxt_rdata = '0;
    case (REG_ADDR)
      nac_pkg::OFF_CTRL:   nxt_rdata = ctrl_rd;
      nac_pkg::OFF_UNLOCK: nxt_rdata = '0;
      nac_pkg::OFF_DATA:   nxt_rdata = data_ff;
      nac_pkg::OFF_ADL:    nxt_rdata = adl_ff;
      nac_pkg::OFF_ADH:    nxt_rdata = {{(nac_pkg::DW-nac_pkg::AH_W){1'h0}}, adh_ff};
      nac_pkg::OFF_TPL:    nxt_rdata = tpl_ff;
      nac_pkg::OFF_TPH:    nxt_rdata = tph_ff;
      nac_pkg::OFF_TPU:    nxt_rdata = {{(nac_pkg::DW-nac_pkg::TPU_W){1'h0}}, tpu_ff};
      nac_pkg::OFF_TABLE_DATA_LATCH: nxt_rdata = table_data_latch_ff;
      nac_pkg::OFF_PERIPHERAL_FLAGS_TWO:   nxt_rdata = peripheral_flags_two_ff;
      nac_pkg::OFF_PERIPHERAL_ENABLES_TWO:   nxt_rdata = peripheral_enables_two_ff;
      nac_pkg::OFF_PERIPHERAL_PRIORITY_TWO:   nxt_rdata = peripheral_priority_two_ff;
      nac_pkg::OFF_INTERRUPT_CONTROL: nxt_rdata = interrupt_control_ff;
      default:             nxt_rdata = '0;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_ff <= '0;
    end else if (CE) begin
      rdata_ff <= REG_RD ? nxt_rdata : '0;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA       = rdata_ff;
  assign NVM_BUSY        = wr_ff;
  assign FLASH_ERASE_STB = erase_stb_ff;
  assign FLASH_WRITE_STB = write_stb_ff;
  assign CFG_WRITE_STB   = cfg_stb_ff;
  assign FLASH_ADDR      = {tpu_ff, tph_ff, tpl_ff};
  assign FLASH_DATA      = table_data_latch_ff;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_launch_guard;
    $rose(wr_ff) |-> $past(seq_ff == nac_pkg::SEQ_ARMED) && $past(write_enable_bit_ff);
  endproperty
  a_launch_guard: assert property (p_launch_guard) else $error("launch unguarded");
  property p_same_write;
    (CE && take && !write_enable_bit_ff && REG_WDATA[nac_pkg::B_WRITE_ENABLE_BIT] && REG_WDATA[nac_pkg::B_WR])
      |=> !wr_ff && write_error_flag_ff;
  endproperty
  a_same_write: assert property (p_same_write) else $error("enable and start together");
  property p_err_on_launch;
    $rose(wr_ff) |-> write_error_flag_ff && !rd_ff;
  endproperty
  a_err_on_launch: assert property (p_err_on_launch) else $error("error flag not set");
  property p_done;
    (CE && arr.done && !soft_rst) |=> !wr_ff && !write_error_flag_ff && peripheral_flags_two_ff[nac_pkg::B_DONE];
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");
  property p_frozen;
    (wr_ff && $past(wr_ff)) |-> $stable(data_ff) && $stable(adl_ff) && $stable(pgd_ff)
                                && $stable(config_space_select_ff) && $stable(write_enable_bit_ff);
  endproperty
  a_frozen: assert property (p_frozen) else $error("register changed while busy");
  property p_read;
    $rose(rd_ff) |-> data_ff == $past(arr.rd_data) ##1 !rd_ff[*2];
  endproperty
  a_read: assert property (p_read) else $error("read byte or start bit wrong");
  property p_rd_refuse;
    rd_ff |-> !pgd_ff && !config_space_select_ff;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("read start in wrong space");
  property p_unlock_zero;
    $past(CE && hit(REG_RD, REG_ADDR, nac_pkg::OFF_UNLOCK)) |-> REG_RDATA == '0;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
  property p_unimp;
    $past(CE && hit(REG_RD, REG_ADDR, nac_pkg::OFF_CTRL)) |-> !REG_RDATA[nac_pkg::B_UNIMP];
  endproperty
  a_unimp: assert property (p_unimp) else $error("unimplemented bit set");
  property p_soft_keep;
    (CE && soft_rst && wr_ff) |=> write_error_flag_ff && !wr_ff;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("error flag lost on reset");

  c_data_write: cover property ($fell(wr_ff) && !free_op_ff && !soft_rst);
  c_read:       cover property ($rose(rd_ff));
  c_erase:      cover property (erase_stb_ff);
  c_abort:      cover property (soft_rst && wr_ff);
endmodule
`default_nettype wire

// >>> verif/nac_flash_model.sv
// Model of the flash and config arrays on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module nac_flash_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ers,
  input  wire logic        wrs,
  input  wire logic        cfs,
  input  wire logic [21:0] addr,
  output var  int          n_ops,
  output var  logic [2:0]  kind,
  output var  logic [21:0] last
);
  // Count launched array cycles, keep kind and target
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_ops <= 0;
      kind  <= 3'h0;
      last  <= 22'h0;
    end else if (ers | wrs | cfs) begin
      n_ops <= n_ops + 1;
      kind  <= {ers, wrs, cfs};
      last  <= addr;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_nac_top.sv
// Self-checking bench of the nonvolatile access control block
`timescale 1ns/1ps
`default_nettype none
module tb_nac_top;
  logic clk = 1'b0, rst = 1'b1, ext_n = 1'b1, wdt = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata, rv, fdata;
  logic busy, ers, wrs, cfs;
  logic ce = 1'b1;
  logic [21:0] faddr, last;
  logic [2:0] kind;
  int n_ops, err_count = 0, checked = 0;
  logic [7:0] bases [3] = '{8'h80, 8'h90, 8'h40};
  logic [7:0] ends [3] = '{8'h84, 8'h84, 8'h44};
  logic [2:0] kinds [3] = '{3'h2, 3'h4, 3'h1};
  nac_top i_nac_top (.CORE_CLK(clk), .SYS_RST(rst), .CE(ce), .EXT_RESET_N(ext_n),
    .WDT_TIMEOUT(wdt), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .NVM_BUSY(busy), .FLASH_ERASE_STB(ers), .FLASH_WRITE_STB(wrs),
    .CFG_WRITE_STB(cfs), .FLASH_ADDR(faddr), .FLASH_DATA(fdata));
  nac_flash_model i_nac_flash_model (.clk(clk), .rst(rst), .ers(ers), .wrs(wrs),
    .cfs(cfs), .addr(faddr), .n_ops(n_ops), .kind(kind), .last(last));
  // Clock at 50 MHz
  always #10 clk = ~clk;
  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rreg(a);
    chk(rv, e);
  endtask
  // Unlock pair, then set the start bit with write enable already set
  task automatic launch(input logic [7:0] b);
    wreg(4'h0, b | 8'h04); wreg(4'h1, 8'h55); wreg(4'h1, 8'haa); wreg(4'h0, b | 8'h06);
  endtask
  task automatic waitdone;
    // Let the launching edge settle before polling busy
    @(posedge clk);
    for (int i = 0; i < 400 && busy; i++) @(posedge clk);
    chk(busy, 1'b0);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence of tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(4'h0, 8'h00);
    wreg(4'h1, 8'h55); rchk(4'h1, 8'h00);
    wreg(4'h0, 8'h20); rchk(4'h0, 8'h00);
    rchk(4'hf, 8'h00);
    $display("test reset values done");
    wreg(4'h3, 8'ha5); wreg(4'h4, 8'h03); wreg(4'h2, 8'h3c); launch(8'h00);
    rchk(4'h0, 8'h0e);
    wreg(4'h2, 8'h00); wreg(4'h3, 8'h00); wreg(4'h0, 8'h00);
    rchk(4'h2, 8'h3c);
    rchk(4'h0, 8'h0e);
    repeat (150) @(posedge clk);
    chk(busy, 1'b1);
    waitdone;
    rchk(4'h0, 8'h04); rchk(4'h9, 8'h10);
    wreg(4'h9, 8'h00); rchk(4'h9, 8'h00);
    wreg(4'h2, 8'h00); wreg(4'h0, 8'h05);
    rchk(4'h2, 8'h3c); rchk(4'h0, 8'h04);
    $display("test data write done");
    wreg(4'h1, 8'h55); wreg(4'h2, 8'h11); wreg(4'h1, 8'haa); wreg(4'h0, 8'h06);
    rchk(4'h0, 8'h0c); chk(busy, 1'b0);
    wreg(4'h0, 8'h00); wreg(4'h1, 8'h55); wreg(4'h1, 8'haa); wreg(4'h0, 8'h06);
    rreg(4'h0); chk(rv & 8'h0b, 8'h08);
    wreg(4'h0, 8'h81); rchk(4'h0, 8'h80);
    @(posedge clk); ce <= 1'b0;
    wreg(4'h3, 8'h77); ce <= 1'b1;
    rchk(4'h3, 8'ha5);
    $display("test refusals done");
    wreg(4'h5, 8'h12); wreg(4'h6, 8'h34); wreg(4'h7, 8'hff);
    wreg(4'h8, 8'h5a); rchk(4'h8, 8'h5a);
    chk(fdata, 8'h5a);
    for (int k = 0; k < 3; k++) begin
      launch(bases[k]);
      waitdone;
      rchk(4'h0, ends[k]);
      chk(kind, kinds[k]);
      chk(last, 22'h3f3412);
      chk(22'(n_ops), 22'(k + 1));
    end
    $display("test flash and config done");
    for (int k = 0; k < 2; k++) begin
      launch(8'h80);
      repeat (10) @(posedge clk);
      ext_n <= (k != 0); wdt <= (k != 0);
      repeat (4) @(posedge clk);
      ext_n <= 1'b1; wdt <= 1'b0;
      repeat (4) @(posedge clk);
      chk(busy, 1'b0); rchk(4'h0, 8'h88);
    end
    $display("test soft reset done");
    close_out;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule
`default_nettype wire
